// [hdl/sram_pkg.sv]
// Shared constants and types for the pipelined synchronous SRAM link
package sram_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 18;
  localparam int BYTE_W = 9;
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_PARK = 18'h00000;
  localparam logic [DATA_W-1:0] DATA_PARK = 18'h00000;
  localparam logic [1:0] BYTES_NONE = 2'h0;
  localparam logic [1:0] BYTES_ALL = 2'h3;
  // Clock divider for the gated SRAM clock: one enable per this many clk_i cycles
  localparam int CLK_DIV = 2;
  localparam logic [3:0] DIV_LAST = 4'h1;
  typedef enum logic [1:0] {HALT_NONE, HALT_READ, HALT_WRITE, HALT_DESEL} halt_kind_type;
  // Next burst address, linear or interleaved
  function automatic logic [BURST_W-1:0] burst_next(input logic [BURST_W-1:0] base,
      input logic [BURST_W-1:0] cnt, input logic linear);
    logic [BURST_W-1:0] c;
    c = cnt + BURST_ONE;
    return linear ? (base + c) : (base ^ c);
  endfunction
endpackage

// [hdl/sram_if.sv]
// Pin-level interface between the SRAM and its controlling host
`timescale 1ns/1ps
interface sram_if;
  import sram_pkg::*;
  logic clk_en;
  logic [ADDR_W-1:0] addr;
  logic processor_address_strobe_n;
  logic controller_address_strobe_n;
  logic burst_advance_n;
  logic select_active_low_first_n;
  logic select_active_high_second;
  logic select_active_low_third_n;
  logic burst_order_select;
  logic write_n;
  logic [1:0] byte_we;
  logic [DATA_W-1:0] dq_host;
  logic dq_host_oe;
  logic [DATA_W-1:0] dq_dev;
  logic dq_dev_oe;
  modport host (output clk_en, addr, processor_address_strobe_n, controller_address_strobe_n,
    burst_advance_n, select_active_low_first_n, select_active_high_second, select_active_low_third_n,
    burst_order_select, write_n, byte_we, dq_host, dq_host_oe, input dq_dev, dq_dev_oe);
  modport dev (input clk_en, addr, processor_address_strobe_n, controller_address_strobe_n,
    burst_advance_n, select_active_low_first_n, select_active_high_second, select_active_low_third_n,
    burst_order_select, write_n, byte_we, dq_host, dq_host_oe, output dq_dev, dq_dev_oe);
endinterface

// [hdl/sram_array.sv]
// Storage array with byte-lane writes
`timescale 1ns/1ps
module sram_array
  import sram_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock
  input wire logic clk_i,
  // Access
  input wire logic en_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [1:0] we_i,
  input wire logic [DATA_W-1:0] wdata_i,
  output logic [DATA_W-1:0] rdata_o
);
  logic [DATA_W-1:0] mem [2**AW];
  // No reset: contents survive any halt of the enable
  always_ff @(posedge clk_i) begin
    if (en_i) begin
      if (we_i[0]) begin
        mem[addr_i][BYTE_W-1:0] <= wdata_i[BYTE_W-1:0];
      end
      if (we_i[1]) begin
        mem[addr_i][DATA_W-1:BYTE_W] <= wdata_i[DATA_W-1:BYTE_W];
      end
      rdata_o <= mem[addr_i];
    end
  end
endmodule

// [hdl/sram_dev.sv]
// Device end: pipelined synchronous burst SRAM with stop-clock support
// Functional notes
// RQ1: All state held while clock stopped
// RQ2: Restart cycle with either strobe starts access
// RQ3: Host stops clock only after last data
// RQ4: Stop read, stop write, stop deselect supported
// RQ5: Host parks clock low when halted
// RQ6: Host holds controls inactive when halted
// RQ7: Host drives addresses low when halted
// RQ8: Host holds write data at steady level
// RQ9: Burst counter bypassable, fresh address each cycle
// RQ10: Non-burst tie levels for strobes and selects
// RQ11: Burst order pin strapped to definite level
// RQ12: Enable needs selects correct on strobe cycle
// RQ13: Restart behaves as if no halt occurred
`timescale 1ns/1ps
module sram_dev
  import sram_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link
  sram_if.dev bus,
  // Status
  output logic selected_o,
  output logic [BURST_W-1:0] burst_cnt_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic ke;
  logic strobe_p;
  logic strobe_c;
  logic sel_ok;
  logic start;
  assign ke = bus.clk_en;
  assign strobe_p = !bus.processor_address_strobe_n;
  assign strobe_c = !bus.controller_address_strobe_n;
  assign sel_ok = !bus.select_active_low_first_n && bus.select_active_high_second &&
                  !bus.select_active_low_third_n;
  // A processor strobe with the first select high starts no access and deselects the device
  assign start = (strobe_c && sel_ok) || (strobe_p && !bus.select_active_low_first_n && sel_ok); // [RQ12]
  ////////////////////////////////////////////////////////////////////////////
  logic [ADDR_W-1:0] base_r, base_nxt;
  logic [BURST_W-1:0] cnt_r, cnt_nxt;
  logic sel_r, sel_nxt;
  logic rd_pipe_r, rd_pipe_nxt;
  logic oe_r, oe_nxt;
  logic [ADDR_W-1:0] cur_addr;
  logic do_access;
  logic is_write;
  logic [1:0] we;
  // Burst word offset; interleaved order xors, so only the plain count is kept
  function automatic logic [BURST_W-1:0] burst_word(input logic [BURST_W-1:0] base,
      input logic [BURST_W-1:0] cnt, input logic linear);
    return linear ? (base + cnt) : (base ^ cnt);
  endfunction
  always_comb begin
    base_nxt = base_r;
    cnt_nxt = cnt_r;
    sel_nxt = sel_r;
    do_access = 1'b0;
    cur_addr = base_r;
    // Everything below advances only on an enabled edge, so a stopped clock freezes it all
    if (ke) begin // [RQ1] [RQ13]
      if (strobe_p || strobe_c) begin // [RQ2]
        sel_nxt = start;
        if (start) begin
          base_nxt = bus.addr; // [RQ9]
          cnt_nxt = BURST_ZERO;
          cur_addr = bus.addr;
          do_access = 1'b1;
        end
      end else if (sel_r && !bus.burst_advance_n) begin
        cnt_nxt = cnt_r + BURST_ONE;
        cur_addr = {base_r[ADDR_W-1:BURST_W], burst_word(base_r[BURST_W-1:0], cnt_nxt, bus.burst_order_select)};
        do_access = 1'b1;
      end else if (sel_r) begin
        // Advance held: repeat current word
        cur_addr = {base_r[ADDR_W-1:BURST_W], burst_word(base_r[BURST_W-1:0], cnt_r, bus.burst_order_select)};
        do_access = 1'b1;
      end
    end
    is_write = do_access && !bus.write_n;
    we = is_write ? bus.byte_we : BYTES_NONE;
    rd_pipe_nxt = ke ? (do_access && bus.write_n) : rd_pipe_r; // [RQ4]
    oe_nxt = ke ? rd_pipe_r : oe_r;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base_r <= ADDR_PARK;
      cnt_r <= BURST_ZERO;
      sel_r <= 1'b0;
      rd_pipe_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      base_r <= base_nxt;
      cnt_r <= cnt_nxt;
      sel_r <= sel_nxt;
      rd_pipe_r <= rd_pipe_nxt;
      oe_r <= oe_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  logic [DATA_W-1:0] arr_q;
  logic [DATA_W-1:0] q_r, q_nxt;
  sram_array #(.AW(AW)) u_array (
    .clk_i(clk_i),
    .en_i(do_access),
    .addr_i(cur_addr[AW-1:0]),
    .we_i(we),
    .wdata_i(bus.dq_host),
    .rdata_o(arr_q)
  );
  // Output register: second stage of the read pipeline
  always_comb begin
    q_nxt = (ke && rd_pipe_r) ? arr_q : q_r;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= DATA_PARK;
      selected_o <= 1'b0;
      burst_cnt_o <= BURST_ZERO;
    end else begin
      q_r <= q_nxt;
      selected_o <= sel_nxt;
      burst_cnt_o <= cnt_nxt;
    end
  end
  assign bus.dq_dev = q_r;
  assign bus.dq_dev_oe = oe_r;
endmodule

// [hdl/sram_host.sv]
// Host end: drives the SRAM in non-burst mode and stops its clock safely
`timescale 1ns/1ps
module sram_host
  import sram_pkg::*;
#(
  parameter logic BURST_ORDER = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link
  sram_if.host bus,
  // User request
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic stop_i,
  // User answer
  output logic busy_o,
  output logic rvalid_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic halted_o,
  output halt_kind_type halt_kind_o
);
  typedef enum logic [2:0] {S_IDLE, S_ACC, S_WAIT1, S_WAIT2, S_DESEL, S_HALT} state_type;
  state_type st_r, st_nxt;
  logic [3:0] div_r, div_nxt;
  logic tick;
  logic rd_r, rd_nxt;
  logic [ADDR_W-1:0] a_r, a_nxt;
  logic [DATA_W-1:0] d_r, d_nxt;
  logic dwr_r, dwr_nxt;
  logic ke_r, ke_nxt;
  logic strobe_r, strobe_nxt;
  logic rv_r, rv_nxt;
  logic [DATA_W-1:0] rq_r, rq_nxt;
  halt_kind_type hk_r, hk_nxt;
  logic desel_r, desel_nxt;
  logic busy_r, busy_nxt;
  logic halted_r, halted_nxt;
  ////////////////////////////////////////////////////////////////////////////
  assign tick = (div_r == DIV_LAST);
  always_comb begin
    div_nxt = tick ? 4'h0 : div_r + 4'h1;
    st_nxt = st_r;
    rd_nxt = rd_r;
    a_nxt = a_r;
    d_nxt = d_r;
    dwr_nxt = dwr_r;
    ke_nxt = 1'b0;
    strobe_nxt = 1'b0;
    hk_nxt = hk_r;
    rv_nxt = 1'b0;
    rq_nxt = rq_r;
    desel_nxt = desel_r;
    if (tick) begin
      unique case (st_r)
        S_IDLE: begin
          ke_nxt = 1'b1;
          if (req_i) begin
            strobe_nxt = 1'b1;
            desel_nxt = 1'b0;
            rd_nxt = !wr_i;
            a_nxt = addr_i;
            d_nxt = wdata_i;
            dwr_nxt = wr_i;
            st_nxt = S_ACC;
          end else if (stop_i) begin
            // Deselect strobe first, so the stop lands on a deselected device
            strobe_nxt = 1'b1; // [RQ4]
            desel_nxt = 1'b1; // [RQ12]
            st_nxt = S_DESEL;
          end
        end
        S_DESEL: begin
          // One more edge lets the device drop its outputs
          ke_nxt = 1'b1;
          hk_nxt = HALT_DESEL; // [RQ4]
          st_nxt = S_HALT;
        end
        S_ACC: begin
          ke_nxt = 1'b1;
          st_nxt = rd_r ? S_WAIT1 : S_WAIT2;
        end
        S_WAIT1: begin
          ke_nxt = 1'b1;
          st_nxt = S_WAIT2;
        end
        S_WAIT2: begin
          // Read data has been driven out, or write latched: safe to stop
          if (rd_r && bus.dq_dev_oe) begin
            rv_nxt = 1'b1;
            rq_nxt = bus.dq_dev;
          end
          if (stop_i) begin // [RQ3]
            hk_nxt = rd_r ? HALT_READ : HALT_WRITE;
            st_nxt = S_HALT;
          end else begin
            ke_nxt = 1'b1;
            st_nxt = S_IDLE;
          end
        end
        S_HALT: begin
          // Restart with a strobe cycle only
          if (req_i) begin // [RQ2]
            ke_nxt = 1'b1;
            strobe_nxt = 1'b1;
            desel_nxt = 1'b0;
            rd_nxt = !wr_i;
            a_nxt = addr_i;
            d_nxt = wdata_i;
            dwr_nxt = wr_i;
            hk_nxt = HALT_NONE;
            st_nxt = S_ACC;
          end else if (!stop_i) begin
            // No access wanted: restart anyway on a strobe, a deselecting one
            ke_nxt = 1'b1; // [RQ2]
            strobe_nxt = 1'b1;
            hk_nxt = HALT_NONE;
            st_nxt = S_IDLE;
          end
        end
      endcase
    end
    if (st_nxt == S_HALT) begin
      a_nxt = ADDR_PARK; // [RQ7]
      d_nxt = DATA_PARK; // [RQ8]
      dwr_nxt = 1'b0;
      desel_nxt = 1'b1; // [RQ6]
    end
    busy_nxt = (st_nxt != S_IDLE) && (st_nxt != S_HALT);
    halted_nxt = (st_nxt == S_HALT);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= S_IDLE;
      div_r <= 4'h0;
      rd_r <= 1'b0;
      a_r <= ADDR_PARK;
      d_r <= DATA_PARK;
      dwr_r <= 1'b0;
      ke_r <= 1'b0;
      strobe_r <= 1'b0;
      hk_r <= HALT_NONE;
      rv_r <= 1'b0;
      rq_r <= DATA_PARK;
      desel_r <= 1'b0;
      busy_r <= 1'b0;
      halted_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      rd_r <= rd_nxt;
      a_r <= a_nxt;
      d_r <= d_nxt;
      dwr_r <= dwr_nxt;
      ke_r <= ke_nxt;
      strobe_r <= strobe_nxt;
      hk_r <= hk_nxt;
      rv_r <= rv_nxt;
      rq_r <= rq_nxt;
      desel_r <= desel_nxt;
      busy_r <= busy_nxt;
      halted_r <= halted_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Clock enable is low between ticks and while halted, i.e. clock parked low
  assign bus.clk_en = ke_r; // [RQ5]
  assign bus.addr = a_r;
  // Non-burst ties; controller strobe pulses per access, idle means inactive controls
  assign bus.processor_address_strobe_n = 1'b1; // [RQ10] [RQ6]
  assign bus.controller_address_strobe_n = !strobe_r; // [RQ10] [RQ6]
  assign bus.burst_advance_n = 1'b1; // [RQ10]
  assign bus.select_active_low_first_n = 1'b0; // [RQ10] [RQ12]
  assign bus.select_active_high_second = 1'b1; // [RQ10] [RQ12]
  // Third select is free of the non-burst ties, so it carries the deselect
  assign bus.select_active_low_third_n = desel_r; // [RQ12]
  assign bus.burst_order_select = BURST_ORDER; // [RQ11]
  assign bus.write_n = !(strobe_r && dwr_r); // [RQ6]
  assign bus.byte_we = (strobe_r && dwr_r) ? BYTES_ALL : BYTES_NONE;
  assign bus.dq_host = d_r;
  assign bus.dq_host_oe = dwr_r;
  assign busy_o = busy_r;
  assign halted_o = halted_r;
  assign halt_kind_o = hk_r;
  assign rvalid_o = rv_r;
  assign rdata_o = rq_r;
endmodule

// [bench/sram_link_monitor.sv]
// Pin checker for the host to SRAM link
`timescale 1ns/1ps
module sram_link_monitor
  import sram_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link pins
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic processor_address_strobe_n,
  input wire logic controller_address_strobe_n,
  input wire logic burst_advance_n,
  input wire logic select_active_low_first_n,
  input wire logic select_active_high_second,
  input wire logic select_active_low_third_n,
  input wire logic burst_order_select,
  input wire logic write_n,
  input wire logic [1:0] byte_we,
  input wire logic [DATA_W-1:0] dq_host,
  input wire logic dq_dev_oe
);
  ////////////////////////////////////////
  // Idle run length; 3 exceeds any divider gap
  logic [3:0] stop_cnt_r;
  logic [3:0] stop_cnt_nxt;
  logic halt_w;
  always_comb begin
    stop_cnt_nxt = clk_en ? 4'h0 : stop_cnt_r + {3'h0, stop_cnt_r != 4'hf};
  end
  always_ff @(posedge clk_i) begin
    stop_cnt_r <= rst_i ? 4'h0 : stop_cnt_nxt;
  end
  assign halt_w = stop_cnt_r >= 4'h3;
  ////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ties;
    processor_address_strobe_n && burst_advance_n && !select_active_low_first_n && select_active_high_second;
  endproperty
  a_ties: assert property (p_ties) else $error("tie level wrong");
  property p_strap;
    $stable(burst_order_select);
  endproperty
  a_strap: assert property (p_strap) else $error("order strap moved");
  property p_halt_quiet;
    halt_w && !clk_en |-> controller_address_strobe_n && write_n && addr == ADDR_PARK;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("pins busy while halted");
  property p_halt_data;
    halt_w && !clk_en |-> $stable(dq_host) && dq_host == DATA_PARK;
  endproperty
  a_halt_data: assert property (p_halt_data) else $error("write data not parked");
  property p_restart;
    halt_w && clk_en |-> !controller_address_strobe_n;
  endproperty
  a_restart: assert property (p_restart) else $error("restart without strobe");
  property p_read;
    clk_en && !controller_address_strobe_n && !select_active_low_third_n && write_n |-> ##[1:8] dq_dev_oe;
  endproperty
  a_read: assert property (p_read) else $error("read not answered");
  property p_desel;
    clk_en && !controller_address_strobe_n && select_active_low_third_n |-> ##[1:4] !dq_dev_oe;
  endproperty
  a_desel: assert property (p_desel) else $error("output kept after deselect");
  property p_write;
    clk_en && !controller_address_strobe_n && !write_n |-> byte_we == BYTES_ALL ##[1:3] clk_en;
  endproperty
  a_write: assert property (p_write) else $error("write not captured");
  property p_frozen;
    $changed(dq_dev_oe) |-> $past(clk_en);
  endproperty
  a_frozen: assert property (p_frozen) else $error("output moved without clock");
endmodule

// [bench/tb_sync_sram_stop_clock_nonburst.sv]
// Bench joining host and SRAM ends
`timescale 1ns/1ps
module tb_sync_sram_stop_clock_nonburst;
  import sram_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_i = 1'b0;
  logic wr_i = 1'b0;
  logic stop_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = ADDR_PARK;
  logic [DATA_W-1:0] wdata_i = DATA_PARK;
  logic busy_o, rvalid_o, halted_o, selected_o;
  logic [DATA_W-1:0] rdata_o;
  logic [BURST_W-1:0] burst_cnt_o;
  halt_kind_type halt_kind_o;
  int num_errors = 0;
  int comparisons = 0;
  logic [ADDR_W-1:0] addrs [4] = '{18'h00000, 18'h000ff, 18'h00055, 18'h000aa};
  logic [DATA_W-1:0] datas [4] = '{18'h3ffff, 18'h00000, 18'h2aaaa, 18'h15555};
  sram_if link();
  always #12.5 clk_i = ~clk_i;
  sram_host sram_host_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(link.host), .req_i(req_i), .wr_i(wr_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .stop_i(stop_i), .busy_o(busy_o), .rvalid_o(rvalid_o),
    .rdata_o(rdata_o), .halted_o(halted_o), .halt_kind_o(halt_kind_o));
  sram_dev sram_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(link.dev), .selected_o(selected_o),
    .burst_cnt_o(burst_cnt_o));
  sram_link_monitor sram_link_monitor_inst (.clk_i(clk_i), .rst_i(rst_i), .clk_en(link.clk_en),
    .addr(link.addr), .processor_address_strobe_n(link.processor_address_strobe_n),
    .controller_address_strobe_n(link.controller_address_strobe_n), .burst_advance_n(link.burst_advance_n),
    .select_active_low_first_n(link.select_active_low_first_n),
    .select_active_low_third_n(link.select_active_low_third_n),
    .select_active_high_second(link.select_active_high_second), .burst_order_select(link.burst_order_select),
    .write_n(link.write_n), .byte_we(link.byte_we), .dq_host(link.dq_host), .dq_dev_oe(link.dq_dev_oe));
  ////////////////////////////////////////
  task automatic check_data(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %0s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_kind(input halt_kind_type exp, input halt_kind_type got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value halt kind expected %0d seen %0d", exp, got);
    end
  endtask
  // A hung handshake ends the run instead of stalling it
  task automatic give_up(input int n);
    if (n >= 200) begin
      num_errors++;
      results();
    end
  endtask
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      input logic stp);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    req_i = 1'b1;
    wr_i = wr;
    addr_i = a;
    wdata_i = d;
    stop_i = stp;
    while (busy_o !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    req_i = 1'b0;
    while (n < 200 && !((busy_o === 1'b0 || halted_o === 1'b1) && (wr || seen))) begin
      @(negedge clk_i);
      seen = seen | (rvalid_o === 1'b1);
      n++;
    end
    give_up(n);
    if (!wr) begin
      check_data("read data", d, rdata_o);
    end
  endtask
  task automatic check_halt(input halt_kind_type kind);
    int n;
    n = 0;
    while (halted_o !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    give_up(n);
    check_kind(kind, halt_kind_o);
    repeat (20) @(negedge clk_i);
    check_data("clock enable", 18'h0, {17'h0, link.clk_en});
    check_data("address", ADDR_PARK, link.addr);
    check_data("write data", DATA_PARK, link.dq_host);
    check_data("strobe", 18'h1, {17'h0, link.controller_address_strobe_n});
    check_data("ties", 18'h3, {16'h0, link.processor_address_strobe_n, link.burst_advance_n});
    check_data("order strap", 18'h0, {17'h0, link.burst_order_select});
    check_data("burst offset", 18'h0, {16'h0, burst_cnt_o});
    check_data("selected", {17'h0, kind != HALT_DESEL}, {17'h0, selected_o});
    stop_i = 1'b0;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      access(1'b1, addrs[i], datas[i], 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      access(1'b0, addrs[i], datas[i], 1'b0);
    end
    $display("test nonburst done");
    access(1'b1, addrs[0], 18'h0abcd, 1'b1);
    check_halt(HALT_WRITE);
    access(1'b0, addrs[0], 18'h0abcd, 1'b0);
    $display("test stop write done");
    access(1'b0, addrs[2], datas[2], 1'b1);
    check_halt(HALT_READ);
    access(1'b0, addrs[1], datas[1], 1'b0);
    $display("test stop read done");
    stop_i = 1'b1;
    check_halt(HALT_DESEL);
    repeat (8) @(negedge clk_i);
    access(1'b0, addrs[3], datas[3], 1'b0);
    $display("test stop deselect done");
    results();
  end
endmodule
